// file: rtl/sdr_regs.vh
// constants for the driver status read-back word and the serial frame
// assumes inclusion by bare name from the rtl folder
`ifndef SDR_REGS_VH
`define SDR_REGS_VH
`define SDR_FRAME_BITS 20
`define SDR_CNT_W 5
`define SDR_SEL_MICROSTEP_TABLE_POSITION 2'h0
`define SDR_SEL_LOAD 2'h1
`define SDR_SEL_LOADSC 2'h2
`define SDR_STAT_UPPER_LSB 10
`define SDR_STAT_STANDSTILL 7
`define SDR_STAT_OPEN_LOAD 5
`define SDR_STAT_SHORT_GND 3
`define SDR_STAT_OT_WARN 2
`define SDR_STAT_OT_SHDN 1
`define SDR_STAT_LOAD_THR 0
`define SDR_CFG_SEL_LSB 4
`define SDR_CFG_RESET 20'h00000
`define SDR_STANDSTILL_FLAG_CYCLES 1048576
`define SDR_STANDSTILL_FLAG_W 21
`define SDR_SHORT_LIMIT 2'h2
`define SDR_CUR_SIXTEENTH 5'h02
`endif

// file: rtl/sdr_sync.v
// two flip-flop synchroniser for one level from outside the clock domain
// assumes the input has no timing relation to i_clk
`timescale 1ns/1ps
module sdr_sync #(
  // level held through reset, the idle level of the pin
  parameter [0:0] RST_VAL = 1'b0
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // level
  input wire i_d,
  output reg o_q
);
  reg meta;
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      meta <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

// file: rtl/sdr_status.v
// serial shift register and driver status read-back word of a stepper driver
// assumes the serial master's clock is at most an eighth of I_SYS_CLK
`timescale 1ns/1ps
`include "sdr_regs.vh"
module sdr_status (
  // clock and reset
  input wire I_SYS_CLK,
  input wire I_NRST,
  // serial pins
  input wire I_SCK,
  input wire I_CS_N,
  input wire I_SDI,
  output reg O_SDO,
  // step input pin
  input wire I_STEP,
  // driver core status
  input wire I_DRV_ENABLE,
  input wire [9:0] I_MICROSTEP_POS,
  input wire [9:0] I_LOAD_RESULT,
  input wire [4:0] I_CURRENT_SCALE,
  input wire I_LOAD_THR_REACHED,
  input wire I_CHOP_EVENT,
  input wire I_POLARITY_CHANGE,
  input wire [4:0] I_COIL_CURRENT,
  input wire I_HS_SHORT,
  input wire I_OT_WARN,
  input wire I_OT_SHDN,
  // outputs
  output reg O_LOAD_STATUS,
  output reg O_CHOP_END,
  output reg O_SHORT_SHUTDOWN,
  output reg [19:0] O_DRIVER_CONFIG_REGISTER
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire sck_s;
  wire cs_n_s;
  wire sdi_s;
  wire step_s;
  sdr_sync u_sck (.i_clk(I_SYS_CLK), .i_nrst(I_NRST), .i_d(I_SCK), .o_q(sck_s));
  // select resets to its idle high level, else reset looks like a frame start
  // and the following release would latch a stray word into the config
  sdr_sync #(
    .RST_VAL(1'b1)
  ) u_csn (
    .i_clk(I_SYS_CLK),
    .i_nrst(I_NRST),
    .i_d(I_CS_N),
    .o_q(cs_n_s)
  );
  sdr_sync u_sdi (.i_clk(I_SYS_CLK), .i_nrst(I_NRST), .i_d(I_SDI), .o_q(sdi_s));
  sdr_sync u_step (.i_clk(I_SYS_CLK), .i_nrst(I_NRST), .i_d(I_STEP), .o_q(step_s));

  // ----------------------------------------
  // edge helpers
  // ----------------------------------------
  function rise_of;
    input now;
    input was;
    begin
      rise_of = now & ~was;
    end
  endfunction

  function fall_of;
    input now;
    input was;
    begin
      fall_of = ~now & was;
    end
  endfunction

  // ----------------------------------------
  // edge detection on synchronised pins
  // ----------------------------------------
  // delay regs reset to the idle level of each pin, so no false edge
  reg sck_d;
  reg cs_n_d;
  reg step_d;
  wire sck_rise = rise_of(sck_s, sck_d);
  wire sck_fall = fall_of(sck_s, sck_d);
  wire cs_fall = fall_of(cs_n_s, cs_n_d);
  wire cs_rise = rise_of(cs_n_s, cs_n_d);
  wire step_rise = rise_of(step_s, step_d);

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  reg [`SDR_STANDSTILL_FLAG_W-1:0] idle_cnt;
  reg standstill_flag;
  reg open_load_flag;
  reg chop_seen;
  reg [1:0] short_cnt;
  reg short_ground_flag;
  reg drv_en_d;
  reg overtemp_prewarning_flag;
  reg overtemp_shutdown_flag;
  reg load_threshold_flag;

  always @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      idle_cnt <= {`SDR_STANDSTILL_FLAG_W{1'b0}};
      standstill_flag <= 1'b0;
      open_load_flag <= 1'b0;
      chop_seen <= 1'b0;
      short_cnt <= 2'h0;
      short_ground_flag <= 1'b0;
      drv_en_d <= 1'b0;
      overtemp_prewarning_flag <= 1'b0;
      overtemp_shutdown_flag <= 1'b0;
      load_threshold_flag <= 1'b0;
      O_LOAD_STATUS <= 1'b0;
      O_CHOP_END <= 1'b0;
      O_SHORT_SHUTDOWN <= 1'b0;
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
      step_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
      cs_n_d <= cs_n_s;
      step_d <= step_s;
      // counter saturates so the flag holds through long idle periods
      if (step_rise) begin
        idle_cnt <= {`SDR_STANDSTILL_FLAG_W{1'b0}};
        standstill_flag <= 1'b0;
      end else if (idle_cnt == (`SDR_STANDSTILL_FLAG_CYCLES - 1)) begin
        standstill_flag <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + {{(`SDR_STANDSTILL_FLAG_W-1){1'b0}}, 1'b1};
      end
      // judged at each polarity change; the set wins over the current clear
      if (I_POLARITY_CHANGE) begin
        chop_seen <= 1'b0;
        if (!chop_seen && !I_CHOP_EVENT) begin
          open_load_flag <= 1'b1;
        end else if (I_COIL_CURRENT > `SDR_CUR_SIXTEENTH) begin
          open_load_flag <= 1'b0;
        end
      end else begin
        if (I_CHOP_EVENT) begin
          chop_seen <= 1'b1;
        end
        if (I_COIL_CURRENT > `SDR_CUR_SIXTEENTH) begin
          open_load_flag <= 1'b0;
        end
      end
      // short shutdown stays until an enable rising edge
      drv_en_d <= I_DRV_ENABLE;
      O_CHOP_END <= I_HS_SHORT;
      if (I_DRV_ENABLE && !drv_en_d) begin
        short_cnt <= 2'h0;
        short_ground_flag <= 1'b0;
        O_SHORT_SHUTDOWN <= 1'b0;
      end else if (I_HS_SHORT && short_cnt != `SDR_SHORT_LIMIT) begin
        short_cnt <= short_cnt + 2'h1;
        if (short_cnt + 2'h1 == `SDR_SHORT_LIMIT) begin
          short_ground_flag <= 1'b1;
          O_SHORT_SHUTDOWN <= 1'b1;
        end
      end
      overtemp_prewarning_flag <= I_OT_WARN;
      overtemp_shutdown_flag <= I_OT_SHDN;
      load_threshold_flag <= I_LOAD_THR_REACHED;
      O_LOAD_STATUS <= I_LOAD_THR_REACHED;
    end
  end

  // ----------------------------------------
  // status word assembly
  // ----------------------------------------
  wire [1:0] readback_select = O_DRIVER_CONFIG_REGISTER[`SDR_CFG_SEL_LSB+1:`SDR_CFG_SEL_LSB];
  reg [9:0] upper;
  always @* begin
    case (readback_select)
      `SDR_SEL_MICROSTEP_TABLE_POSITION: upper = I_MICROSTEP_POS;
      `SDR_SEL_LOAD: upper = I_LOAD_RESULT;
      `SDR_SEL_LOADSC: upper = {I_LOAD_RESULT[9:5], I_CURRENT_SCALE};
      // reserved setting, master must avoid it
      default: upper = 10'h000;
    endcase
  end
  // reserved positions stay zero
  wire [19:0] driver_status_word = {upper, 2'h0, standstill_flag, 1'b0, open_load_flag, 1'b0,
    short_ground_flag, overtemp_prewarning_flag, overtemp_shutdown_flag, load_threshold_flag};

  // ----------------------------------------
  // serial shift register
  // ----------------------------------------
  reg [19:0] shift;
  always @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      shift <= 20'h00000;
      O_SDO <= 1'b0;
      O_DRIVER_CONFIG_REGISTER <= `SDR_CFG_RESET;
    end else begin
      if (cs_fall) begin
        shift <= driver_status_word;
        O_SDO <= driver_status_word[19];
      end else if (!cs_n_s && sck_rise) begin
        // a plain 20-bit shifter passes extra bits through delayed 20
        shift <= {shift[18:0], sdi_s};
      end else if (!cs_n_s && sck_fall) begin
        // moving on the fall gives the master a settled bit at its next rise
        O_SDO <= shift[19];
      end
      if (cs_rise) begin
        O_DRIVER_CONFIG_REGISTER <= shift;
      end
    end
  end
endmodule

// file: verif/sdr_status_sva.sv
// port checks for the status read-back block
// assumes binding onto sdr_status
`timescale 1ns/1ps
module sdr_status_sva (
  input wire I_SYS_CLK, I_NRST, I_SCK, I_CS_N, O_SDO,
  input wire I_DRV_ENABLE, I_LOAD_THR_REACHED, I_HS_SHORT,
  input wire O_LOAD_STATUS, O_CHOP_END, O_SHORT_SHUTDOWN,
  input wire [19:0] O_DRIVER_CONFIG_REGISTER
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  a_load_pin: assert property ($past(I_NRST) |-> O_LOAD_STATUS == $past(I_LOAD_THR_REACHED))
    else $error("load pin");
  a_chop_end: assert property (I_HS_SHORT |=> O_CHOP_END)
    else $error("no chop end");
  a_chop_cause: assert property (O_CHOP_END |-> $past(I_HS_SHORT))
    else $error("stray chop end");
  a_short_cause: assert property ($rose(O_SHORT_SHUTDOWN) |-> $past(I_HS_SHORT))
    else $error("stray shutdown");
  a_short_hold: assert property (O_SHORT_SHUTDOWN && I_DRV_ENABLE && $past(I_DRV_ENABLE) |=> O_SHORT_SHUTDOWN)
    else $error("shutdown lost");
  a_cfg_stable: assert property (!I_CS_N [*5] |-> $stable(O_DRIVER_CONFIG_REGISTER))
    else $error("config moved");
  a_sdo_steady: assert property (I_SCK [*3] |-> $stable(O_SDO))
    else $error("sdo moved");
  a_sdo_idle: assert property (I_CS_N [*5] |-> $stable(O_SDO))
    else $error("sdo moved idle");
  c_short: cover property ($rose(O_SHORT_SHUTDOWN));
  c_cfg: cover property ($changed(O_DRIVER_CONFIG_REGISTER));
  c_load: cover property ($rose(O_LOAD_STATUS));
endmodule
bind sdr_status sdr_status_sva chk_u (.*);

// file: verif/sdr_spi_master.sv
// serial master model, 20-bit frames, clock idle low
// assumes a free running clk
`timescale 1ns/1ps
module sdr_spi_master (
  input wire clk,
  input wire sdo,
  output reg sck = 1'b0,
  output reg cs_n = 1'b1,
  output reg sdi = 1'b0
);
  // four clk per half period leaves room for the 2-ff sync
  task xfer(input [19:0] d, output [19:0] q);
    integer i;
    begin
      @(posedge clk) cs_n <= 1'b0;
      for (i = 19; i >= 0; i = i - 1) begin
        @(posedge clk) sdi <= d[i];
        repeat (3) @(posedge clk);
        q[i] = sdo;
        sck <= 1'b1;
        repeat (4) @(posedge clk);
        sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      sdi <= ~sdi;
      repeat (6) @(posedge clk);
    end
  endtask
endmodule

// file: verif/sdr_status_tb.sv
// bench for the status read-back block
// assumes the master model and checker of this folder
`timescale 1ns/1ps
module sdr_status_tb;
  reg clk = 0, nrst = 0, ena = 0, step = 0, thr = 0, chop = 0, pol = 0, hs = 0, otw = 0, ot = 0;
  reg ol = 0, s2g = 0;
  reg [9:0] pos = 0, ld = 0;
  reg [4:0] sc = 0, cur = 0;
  wire sck, cs_n, sdi, sdo, sd;
  wire [19:0] cfg;
  reg [19:0] r, got;
  reg [19:0] q[$];
  integer fails = 0, check_count = 0, s;
  event seen;
  always #10 clk = ~clk;
  sdr_status dut_u (.I_SYS_CLK(clk), .I_NRST(nrst), .I_SCK(sck), .I_CS_N(cs_n), .I_SDI(sdi),
    .O_SDO(sdo), .I_STEP(step), .I_DRV_ENABLE(ena), .I_MICROSTEP_POS(pos), .I_LOAD_RESULT(ld),
    .I_CURRENT_SCALE(sc), .I_LOAD_THR_REACHED(thr), .I_CHOP_EVENT(chop), .I_POLARITY_CHANGE(pol),
    .I_COIL_CURRENT(cur), .I_HS_SHORT(hs), .I_OT_WARN(otw), .I_OT_SHDN(ot), .O_LOAD_STATUS(),
    .O_CHOP_END(), .O_SHORT_SHUTDOWN(sd), .O_DRIVER_CONFIG_REGISTER(cfg));
  sdr_spi_master m_u (.clk(clk), .sdo(sdo), .sck(sck), .cs_n(cs_n), .sdi(sdi));
  function [19:0] stat(input integer k);
    reg [9:0] up;
    begin
      up = k == 0 ? pos : k == 1 ? ld : k == 2 ? {ld[9:5], sc} : 10'h000;
      stat = {up, 4'h0, ol, 1'b0, s2g, otw, ot, thr};
    end
  endfunction
  task note(input [19:0] g, input [19:0] e);
    begin
      q.push_back(e);
      got = g;
      ->seen;
      #1;
    end
  endtask
  always @(seen) begin
    check_count = check_count + 1;
    if (got !== q.pop_front()) begin
      fails = fails + 1;
      $display("MISMATCH %0t got %h", $time, got);
    end
  end
  task test_done;
    begin
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task rd;
    m_u.xfer(20'h00000, r);
  endtask
  initial begin
    s = $urandom(32'h5a34dfd6);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    ena <= 1'b1;
    // select 11 is reserved and never programmed
    for (s = 0; s < 3; s = s + 1) begin
      @(posedge clk) {pos, ld, sc, otw, ot, thr, step} <= 29'($urandom);
      m_u.xfer({14'h0, s[1:0], 4'h0}, r);
      note(cfg, {14'h0, s[1:0], 4'h0});
      rd;
      note(r, stat(s));
    end
    $display("test select done");
    for (s = 0; s < 2; s = s + 1) begin
      @(posedge clk) hs <= 1'b1;
      @(posedge clk) hs <= 1'b0;
      repeat (3) @(posedge clk);
      note({19'h0, sd}, 20'(s));
    end
    s2g = 1'b1;
    rd;
    note(r, stat(0));
    @(posedge clk) ena <= 1'b0;
    repeat (4) @(posedge clk);
    note({19'h0, sd}, 20'h00001);
    @(posedge clk) ena <= 1'b1;
    repeat (4) @(posedge clk);
    s2g = 1'b0;
    note({19'h0, sd}, 20'h00000);
    $display("test short done");
    @(posedge clk) chop <= 1'b1;
    @(posedge clk) {chop, pol} <= 2'b01;
    @(posedge clk) {cur, pol} <= 6'h04;
    rd;
    note(r, stat(0));
    @(posedge clk) pol <= 1'b1;
    @(posedge clk) pol <= 1'b0;
    ol = 1'b1;
    rd;
    note(r, stat(0));
    @(posedge clk) cur <= 5'h03;
    ol = 1'b0;
    rd;
    note(r, stat(0));
    $display("test open load done");
    test_done;
  end
endmodule
